// ==== dwec_pkg.sv ====
package dwec_pkg;

  // ------------------------------------------------------------------
  // Register offsets (byte addresses, one word each)
  // ------------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL      = 12'h000; // check_code_control_reg
  localparam logic [11:0] OFS_RAW       = 12'h004; // irq_raw_flags_reg (read only)
  localparam logic [11:0] OFS_ENSET     = 12'h008; // irq_enable_set_reg
  localparam logic [11:0] OFS_ENCLR     = 12'h00C; // enable clear
  localparam logic [11:0] OFS_CLR       = 12'h010; // raw flag clear (write only)
  localparam logic [11:0] OFS_RNG_LO    = 12'h014; // protected range base
  localparam logic [11:0] OFS_RNG_HI    = 12'h018; // protected range limit (inclusive)
  localparam logic [11:0] OFS_COUNT     = 12'h01C; // flagged write counter

  // ------------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------------
  localparam int BIT_MERGE_EN    = 0; // merge_write_enable
  localparam int BIT_WR_ERR      = 0; // write check error flag / enable
  localparam int BIT_RD_ERR      = 1; // read check error flag / enable
  localparam int NUM_FLAGS       = 2;

  localparam logic [31:0] RST_CTRL   = 32'h0000_0000;
  localparam logic [31:0] RST_RNG_LO = 32'h0000_0000;
  localparam logic [31:0] RST_RNG_HI = 32'hFFFF_FFFF;

  localparam int QUANTUM_BYTES = 8; // 64-bit unit

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_ERR  = 2'h2;

  // ------------------------------------------------------------------
  // Carriers
  // ------------------------------------------------------------------
  typedef struct packed {
    logic        write;   // 1 write, 0 read
    logic [31:0] addr;    // byte address
    logic [15:0] bytes;   // byte count
    logic        anyBe;   // at least one byte enable set
    logic        rdErr;   // uncorrectable read check error seen by datapath
  } dwec_req_s;

  typedef struct packed {
    logic        issue;   // forward write to DRAM
    logic        merge;   // service through read-modify-write
    logic        err;     // write check error detected
  } dwec_dec_s;

endpackage

// ==== dwec_check.sv ====
`timescale 1ns/1ps
// Pure combinational write classification.
module dwec_check (
  input  wire dwec_pkg::dwec_req_s req,     // Request under test
  input  wire logic                mergeEn, // Read-modify-write enabled
  input  wire logic [31:0]         rngLo,   // Protected base
  input  wire logic [31:0]         rngHi,   // Protected limit
  output dwec_pkg::dwec_dec_s      dec      // Decision
);

  localparam logic [31:0] QMASK = 32'(dwec_pkg::QUANTUM_BYTES - 1);
  localparam logic [15:0] QMASK16 = 16'(dwec_pkg::QUANTUM_BYTES - 1);

  wire inRange   = (req.addr >= rngLo) && (req.addr <= rngHi);
  wire aligned   = (req.addr & QMASK) == 32'h0000_0000;
  wire wholeQ    = ((req.bytes & QMASK16) == 16'h0000) && (req.bytes != 16'h0000);
  wire violation = req.write && inRange && !(aligned && wholeQ);

  assign dec.err   = violation && !mergeEn;
  assign dec.merge = violation && mergeEn && req.anyBe;
  assign dec.issue = req.write && req.anyBe;

endmodule

// ==== dwec_top.sv ====
// The implementer's own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ps
// What this block does
// - Aligned whole-quantum protected writes never flag
// - Bad protected write without merge sets flag
// - Interrupt needs enable; raw flag always records
// - No-byte-enable write never reaches DRAM
// - Sub-quantum protected write without merge returns error response status
// - Merge enabled services bad writes that have byte enables, without flag
// - Flag sticks until software clears it
// - One shared error interrupt, no master id
// - Error drives nonzero write or read status
module dwec_top (
  input  wire logic                mclk,      // Bus clock 125 MHz
  input  wire logic                reset,     // Synchronous active high
  // APB slave
  input  wire logic                psel,      // Select
  input  wire logic                penable,   // Access phase
  input  wire logic                pwrite,    // Direction
  input  wire logic [11:0]         paddr,     // Byte address
  input  wire logic [31:0]         pwdata,    // Write data
  output logic                     pready,    // Ready
  output logic [31:0]              prdata,    // Read data
  output logic                     pslverr,   // Unmapped or wrong-direction access
  // Master request side
  input  wire logic                reqValid,  // Request pulse
  input  wire dwec_pkg::dwec_req_s req,       // Request fields
  // Responses and datapath controls
  output logic                     rspValid,  // Response pulse
  output logic [1:0]               wrStatus,  // Write response status
  output logic [1:0]               rdStatus,  // Read response status
  output logic                     dramIssue, // Forward write to DRAM
  output logic                     dramMerge, // Use read-modify-write
  output logic                     eccIrq     // Shared error interrupt
);

  // ------------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------------
  logic [31:0]                    ctrl_ff;
  logic [31:0]                    rngLo_ff;
  logic [31:0]                    rngHi_ff;
  logic [dwec_pkg::NUM_FLAGS-1:0] raw_ff;
  logic [dwec_pkg::NUM_FLAGS-1:0] en_ff;
  logic [15:0]                    count_ff;
  logic                           rspValid_ff;
  logic [1:0]                     wrStatus_ff;
  logic [1:0]                     rdStatus_ff;
  logic                           dramIssue_ff;
  logic                           dramMerge_ff;

  // ------------------------------------------------------------------
  // Check
  // ------------------------------------------------------------------
  dwec_pkg::dwec_dec_s dec;

  dwec_check u_check (
    .req     (req),
    .mergeEn (ctrl_ff[dwec_pkg::BIT_MERGE_EN]),
    .rngLo   (rngLo_ff),
    .rngHi   (rngHi_ff),
    .dec     (dec)
  );

  wire wrErrEvt = reqValid && dec.err;
  wire rdErrEvt = reqValid && !req.write && req.rdErr;

  // ------------------------------------------------------------------
  // APB decode
  // ------------------------------------------------------------------
  wire access  = psel && penable;
  wire wrAcc   = access && pwrite;
  wire hitCtrl = paddr == dwec_pkg::OFS_CTRL;
  wire hitRaw  = paddr == dwec_pkg::OFS_RAW;
  wire hitEnS  = paddr == dwec_pkg::OFS_ENSET;
  wire hitEnC  = paddr == dwec_pkg::OFS_ENCLR;
  wire hitClr  = paddr == dwec_pkg::OFS_CLR;
  wire hitLo   = paddr == dwec_pkg::OFS_RNG_LO;
  wire hitHi   = paddr == dwec_pkg::OFS_RNG_HI;
  wire hitCnt  = paddr == dwec_pkg::OFS_COUNT;
  wire mapped  = hitCtrl | hitRaw | hitEnS | hitEnC | hitClr | hitLo | hitHi | hitCnt;
  // Read-only status and write-only clear refuse the wrong direction
  wire badDir  = (pwrite && (hitRaw || hitCnt)) || (!pwrite && hitClr);

  wire [dwec_pkg::NUM_FLAGS-1:0] clrBits = (wrAcc && hitClr) ?
                                            pwdata[dwec_pkg::NUM_FLAGS-1:0] : '0;
  wire [dwec_pkg::NUM_FLAGS-1:0] setBits = {rdErrEvt, wrErrEvt};
  // A new event in the clear cycle survives the clear
  wire [dwec_pkg::NUM_FLAGS-1:0] nxt_raw = (raw_ff & ~clrBits) | setBits;

  wire [dwec_pkg::NUM_FLAGS-1:0] nxt_en =
    (wrAcc && hitEnS) ? (en_ff | pwdata[dwec_pkg::NUM_FLAGS-1:0]) :
    (wrAcc && hitEnC) ? (en_ff & ~pwdata[dwec_pkg::NUM_FLAGS-1:0]) : en_ff;

  wire [31:0] rdMux =
    hitCtrl ? ctrl_ff :
    hitRaw  ? {{(32-dwec_pkg::NUM_FLAGS){1'b0}}, raw_ff} :
    hitEnS  ? {{(32-dwec_pkg::NUM_FLAGS){1'b0}}, en_ff} :
    hitEnC  ? {{(32-dwec_pkg::NUM_FLAGS){1'b0}}, en_ff} :
    hitLo   ? rngLo_ff :
    hitHi   ? rngHi_ff :
    hitCnt  ? {16'h0000, count_ff} : 32'h0000_0000;

  // Zero-wait slave keeps the master simple
  assign pready  = 1'b1;
  assign pslverr = access && (!mapped || badDir);

  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      prdata <= rdMux;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ctrl_ff  <= dwec_pkg::RST_CTRL;
      rngLo_ff <= dwec_pkg::RST_RNG_LO;
      rngHi_ff <= dwec_pkg::RST_RNG_HI;
    end else if (wrAcc) begin
      if (hitCtrl) ctrl_ff <= pwdata & 32'h0000_0001;
      if (hitLo) rngLo_ff <= pwdata;
      if (hitHi) rngHi_ff <= pwdata;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      raw_ff <= '0;
      en_ff  <= '0;
    end else begin
      raw_ff <= nxt_raw;
      en_ff  <= nxt_en;
    end
  end

  // Saturating count of flagged writes, cleared with the write flag
  always_ff @(posedge mclk) begin
    if (reset) begin
      count_ff <= 16'h0000;
    end else if (wrErrEvt && count_ff != 16'hFFFF) begin
      count_ff <= count_ff + 16'h0001;
    end else if (clrBits[dwec_pkg::BIT_WR_ERR] && !wrErrEvt) begin
      count_ff <= 16'h0000;
    end
  end

  // ------------------------------------------------------------------
  // Responses
  // ------------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (reset) begin
      rspValid_ff  <= 1'b0;
      wrStatus_ff  <= dwec_pkg::RESP_OKAY;
      rdStatus_ff  <= dwec_pkg::RESP_OKAY;
      dramIssue_ff <= 1'b0;
      dramMerge_ff <= 1'b0;
    end else begin
      rspValid_ff  <= reqValid;
      wrStatus_ff  <= wrErrEvt ? dwec_pkg::RESP_ERR : dwec_pkg::RESP_OKAY;
      rdStatus_ff  <= rdErrEvt ? dwec_pkg::RESP_ERR : dwec_pkg::RESP_OKAY;
      dramIssue_ff <= reqValid && dec.issue;
      dramMerge_ff <= reqValid && dec.merge;
    end
  end

  assign rspValid  = rspValid_ff;
  assign wrStatus  = wrStatus_ff;
  assign rdStatus  = rdStatus_ff;
  assign dramIssue = dramIssue_ff;
  assign dramMerge = dramMerge_ff;
  // Single level output shared by all masters
  assign eccIrq    = |(raw_ff & en_ff);

  // ------------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------------
  wire aligned8 = req.addr[2:0] == 3'h0 && req.bytes[2:0] == 3'h0 && req.bytes != 16'h0000;
  wire inRng    = req.addr >= rngLo_ff && req.addr <= rngHi_ff;

  sequence s_badWrite;
    reqValid && req.write && inRng && !aligned8 && !ctrl_ff[0];
  endsequence

  sequence s_mergeWrite;
    reqValid && req.write && inRng && !aligned8 && ctrl_ff[0] && req.anyBe;
  endsequence

  sequence s_clearWrite;
    wrAcc && hitClr && pwdata[0];
  endsequence

  a_clean_write_ok: assert property (@(posedge mclk) disable iff (reset)
    reqValid && req.write && aligned8 |=> wrStatus == 2'h0)
    else $error("aligned write flagged");

  a_bad_sets_flag: assert property (@(posedge mclk) disable iff (reset)
    s_badWrite |=> raw_ff[0])
    else $error("bad write did not set flag");

  a_irq_needs_en: assert property (@(posedge mclk) disable iff (reset)
    eccIrq |-> (raw_ff[0] && en_ff[0]) || (raw_ff[1] && en_ff[1]))
    else $error("irq without enable");

  a_irq_follows_en: assert property (@(posedge mclk) disable iff (reset)
    raw_ff[0] && en_ff[0] |-> eccIrq)
    else $error("enabled flag without irq");

  // Raw recording must not depend on the enable
  a_raw_ignores_en: assert property (@(posedge mclk) disable iff (reset)
    s_badWrite ##0 !en_ff[0] |=> raw_ff[0])
    else $error("raw flag gated by enable");

  a_no_be_no_issue: assert property (@(posedge mclk) disable iff (reset)
    reqValid && !req.anyBe |=> !dramIssue && !dramMerge)
    else $error("empty write issued");

  a_bad_err_status: assert property (@(posedge mclk) disable iff (reset)
    s_badWrite |=> rspValid && wrStatus != 2'h0)
    else $error("no error status");

  a_merge_no_flag: assert property (@(posedge mclk) disable iff (reset)
    reqValid && ctrl_ff[0] && !req.rdErr |=> wrStatus == 2'h0)
    else $error("flag despite merge");

  a_flag_sticky: assert property (@(posedge mclk) disable iff (reset)
    raw_ff[0] && !(wrAcc && hitClr && pwdata[0]) |=> raw_ff[0])
    else $error("flag dropped without clear");

  a_out_of_range: assert property (@(posedge mclk) disable iff (reset)
    reqValid && req.write && !inRng |=> wrStatus == 2'h0 && !dramMerge)
    else $error("out of range write flagged");

  a_read_status: assert property (@(posedge mclk) disable iff (reset)
    reqValid && !req.write && req.rdErr |=> rspValid && rdStatus != 2'h0)
    else $error("read error status missing");

  a_rd_err_flag: assert property (@(posedge mclk) disable iff (reset)
    reqValid && !req.write && req.rdErr |=> raw_ff[1])
    else $error("read error flag missing");

  // Responses: exactly one cycle after each request, quiet otherwise
  a_rsp_one_cycle: assert property (@(posedge mclk) disable iff (reset)
    reqValid |=> rspValid)
    else $error("response missing");

  a_rsp_only_req: assert property (@(posedge mclk) disable iff (reset)
    !reqValid |=> !rspValid && wrStatus == 2'h0 && rdStatus == 2'h0)
    else $error("response without request");

  a_be_write_issued: assert property (@(posedge mclk) disable iff (reset)
    reqValid && req.write && req.anyBe |=> dramIssue)
    else $error("write with enables not issued");

  a_rd_no_issue: assert property (@(posedge mclk) disable iff (reset)
    reqValid && !req.write |=> !dramIssue && !dramMerge && wrStatus == 2'h0)
    else $error("read treated as write");

  // The empty trailing write still flags but never reaches memory
  a_empty_flags: assert property (@(posedge mclk) disable iff (reset)
    s_badWrite ##0 !req.anyBe |=> raw_ff[0] && !dramIssue)
    else $error("empty bad write handled wrongly");

  a_aligned_no_merge: assert property (@(posedge mclk) disable iff (reset)
    reqValid && req.write && aligned8 |=> !dramMerge)
    else $error("aligned write merged");

  a_merge_services: assert property (@(posedge mclk) disable iff (reset)
    s_mergeWrite |=> dramMerge && wrStatus == 2'h0)
    else $error("bad write not merged");

  a_merge_keeps_raw: assert property (@(posedge mclk) disable iff (reset)
    reqValid && ctrl_ff[0] && !raw_ff[0] |=> !raw_ff[0])
    else $error("flag set while merging");

  a_clear_drops_flag: assert property (@(posedge mclk) disable iff (reset)
    s_clearWrite ##0 !reqValid |=> !raw_ff[0])
    else $error("clear ignored");

  a_set_beats_clear: assert property (@(posedge mclk) disable iff (reset)
    s_badWrite ##0 s_clearWrite |=> raw_ff[0])
    else $error("new event lost to clear");

  a_count_tracks: assert property (@(posedge mclk) disable iff (reset)
    s_badWrite ##0 count_ff != 16'hFFFF |=> count_ff == $past(count_ff) + 16'h0001)
    else $error("flagged write not counted");

  // Read errors use the same single line as write errors
  a_shared_irq: assert property (@(posedge mclk) disable iff (reset)
    raw_ff[1] && en_ff[1] |-> eccIrq)
    else $error("read error irq missing");

  a_out_range_issue: assert property (@(posedge mclk) disable iff (reset)
    reqValid && req.write && !inRng && req.anyBe |=> dramIssue && !dramMerge)
    else $error("out of range write not issued");

endmodule

// ==== dwec_master_model.sv ====
`timescale 1ns/1ps
// Cache-like master: block or global writeback, plus its own error capture
module dwec_master_model (
  input  wire logic           mclk,      // Bus clock
  input  wire logic           reset,     // Sync reset
  input  wire logic           go,        // Start one writeback
  input  wire logic           globalOp,  // Global rather than block operation
  input  wire logic [31:0]    base,      // Block base address
  input  wire logic [15:0]    lineBytes, // Whole line size
  input  wire logic           clrErr,    // Software clears the capture
  input  wire logic           rspValid,  // Controller response
  input  wire logic [1:0]     wrStatus,  // Write response status
  output logic                reqValid,  // Request pulse
  output dwec_pkg::dwec_req_s req,       // Request fields
  output logic [2:0]          errCode,   // Captured error code
  output logic                errIrq,    // Error interrupt
  input  wire logic [1:0]     rdStatus,  // Read response status
  output logic [31:0]         errAddr,   // Captured failing address
  output logic [3:0]          abortCnt,  // Aborts a bridge would return
  output logic [3:0]          queueCnt   // Errors queued by a logging master
);
  logic        step_ff;
  logic        own_ff;
  logic [31:0] lastAddr_ff;
  wire         ownErr = rspValid && own_ff && wrStatus != 2'h0;
  wire         anyErr = rspValid && (wrStatus != 2'h0 || rdStatus != 2'h0);
  always_ff @(posedge mclk) begin
    if (reset) begin
      reqValid <= 1'b0;
      req      <= '0;
      step_ff  <= 1'b0;
    end else if (go) begin
      reqValid <= 1'b1;
      req      <= '{1'b1, base, lineBytes, 1'b1, 1'b0};
      step_ff  <= 1'b1;
    end else if (step_ff && !globalOp) begin
      reqValid <= 1'b1;
      req      <= '{1'b1, base + {16'h0000, lineBytes} - 32'h1, 16'h0001, 1'b0, 1'b0};
      step_ff  <= 1'b0;
    end else begin
      reqValid <= 1'b0;
      // Idle fields toggle so a stale request is never mistaken for a live one
      req      <= ~req;
      step_ff  <= 1'b0;
    end
  end
  // The response trails the request by one cycle; remember whose it is
  always_ff @(posedge mclk) begin
    if (reset) begin
      own_ff <= 1'b0;
    end else begin
      own_ff <= reqValid;
    end
    lastAddr_ff <= req.addr;
  end
  always_ff @(posedge mclk) begin
    if (reset || clrErr) begin
      errCode <= 3'h0;
      errIrq  <= 1'b0;
      errAddr <= 32'h0;
    end else if (ownErr && !errIrq) begin
      errCode <= 3'h4;
      errIrq  <= 1'b1;
      errAddr <= lastAddr_ff;
    end
  end
  // A bridge aborts reads only; a logging master queues every error
  always_ff @(posedge mclk) begin
    if (reset) begin
      abortCnt <= 4'h0;
      queueCnt <= 4'h0;
    end else begin
      if (rspValid && rdStatus != 2'h0) abortCnt <= abortCnt + 4'h1;
      if (anyErr) queueCnt <= queueCnt + 4'h1;
    end
  end
endmodule

// ==== dwec_top_tb.sv ====
`timescale 1ns/1ps
module dwec_top_tb;
  logic                mclk, reset, psel, penable, pwrite, pready, pslverr, e;
  logic [11:0]         paddr;
  logic [31:0]         pwdata, prdata, q, base, errAddr;
  logic [3:0]          abortCnt, queueCnt;
  logic                tbValid, mValid, reqValid, rspValid, dramIssue, dramMerge, eccIrq;
  logic                go, globalOp, clrErr, errIrq;
  logic [1:0]          wrStatus, rdStatus;
  logic [2:0]          errCode;
  logic [15:0]         lineBytes;
  dwec_pkg::dwec_req_s tbReq, mReq, req;
  int                  fail_count, total_checks, issueCnt;
  assign reqValid = tbValid | mValid;
  assign req      = mValid ? mReq : tbReq;
  dwec_top dut (.mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .reqValid(reqValid), .req(req), .rspValid(rspValid), .wrStatus(wrStatus),
    .rdStatus(rdStatus), .dramIssue(dramIssue), .dramMerge(dramMerge), .eccIrq(eccIrq));
  dwec_master_model mst (.mclk(mclk), .reset(reset), .go(go), .globalOp(globalOp),
    .base(base), .lineBytes(lineBytes), .clrErr(clrErr), .rspValid(rspValid),
    .wrStatus(wrStatus), .reqValid(mValid), .req(mReq), .errCode(errCode), .errIrq(errIrq),
    .rdStatus(rdStatus), .errAddr(errAddr), .abortCnt(abortCnt), .queueCnt(queueCnt));
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end
  always @(posedge mclk) if (rspValid && dramIssue) issueCnt++;
  task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      fail_count++;
      $display("unexpected %s expected %h seen %h", n, x, g);
    end
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    logic r;
    r = 1'b0;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge mclk);
    penable <= 1'b1;
    // Answer and read data are taken at the edge that samples pready high
    for (int i = 0; i < 8 && !r; i++) begin
      @(posedge mclk);
      r = pready;
      q = prdata;
      e = pslverr;
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    #1;
    if (!r) begin
      fail_count++;
      tally_and_finish();
    end
  endtask
  task automatic rdc(input string n, input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0);
    chk(n, x, q);
  endtask
  // Master request and its one-cycle response
  task automatic send(input logic w, input logic [31:0] a, input logic [15:0] b,
                      input logic be, input logic [1:0] st, input logic iss, input logic mg);
    @(posedge mclk);
    tbValid <= 1'b1;
    tbReq   <= '{w, a, b, be, ~w};
    @(posedge mclk);
    tbValid <= 1'b0;
    tbReq   <= ~tbReq;
    #1;
    chk("rspValid", 32'h1, {31'h0, rspValid});
    chk("status", {30'h0, st}, {30'h0, w ? wrStatus : rdStatus});
    chk("dramIssue", {31'h0, iss}, {31'h0, dramIssue});
    chk("dramMerge", {31'h0, mg}, {31'h0, dramMerge});
  endtask
  task automatic wb(input logic g, input logic [31:0] a, input logic [15:0] n);
    @(posedge mclk);
    go        <= 1'b1;
    globalOp  <= g;
    base      <= a;
    lineBytes <= n;
    @(posedge mclk);
    go <= 1'b0;
    repeat (4) @(posedge mclk);
    #1;
  endtask
  initial begin
    {psel, penable, pwrite, tbValid, go, globalOp, clrErr} = '0;
    {paddr, pwdata, base, lineBytes} = '0;
    tbReq = '0;
    reset = 1'b1;
    repeat (4) @(posedge mclk);
    reset <= 1'b0;
    rdc("ctrl", dwec_pkg::OFS_CTRL, dwec_pkg::RST_CTRL);
    rdc("rngHi", dwec_pkg::OFS_RNG_HI, dwec_pkg::RST_RNG_HI);
    rdc("unmapped", 12'h020, 32'h0);
    chk("pslverr", 32'h1, {31'h0, e});
    $display("test reset done");
    send(1'b1, 32'h0000_0100, 16'h0040, 1'b1, dwec_pkg::RESP_OKAY, 1'b1, 1'b0);
    wb(1'b0, 32'h0000_1000, 16'h0080);
    chk("issued", 32'h2, issueCnt);
    chk("eccIrq", 32'h0, {31'h0, eccIrq});
    chk("errCode", 32'h4, {29'h0, errCode});
    chk("errAddr", 32'h0000_107F, errAddr);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h1);
    apb(1'b1, dwec_pkg::OFS_ENSET, 32'h1);
    chk("eccIrq", 32'h1, {31'h0, eccIrq});
    send(1'b1, 32'h0000_1008, 16'h0004, 1'b1, dwec_pkg::RESP_ERR, 1'b1, 1'b0);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h1);
    apb(1'b1, dwec_pkg::OFS_CLR, 32'h1);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h0);
    chk("eccIrq", 32'h0, {31'h0, eccIrq});
    @(posedge mclk);
    clrErr <= 1'b1;
    @(posedge mclk);
    clrErr <= 1'b0;
    wb(1'b1, 32'h0000_2000, 16'h0040);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h0);
    chk("errIrq", 32'h0, {31'h0, errIrq});
    $display("test writeback done");
    apb(1'b1, dwec_pkg::OFS_CTRL, 32'h1);
    send(1'b1, 32'h0000_0104, 16'h0004, 1'b1, dwec_pkg::RESP_OKAY, 1'b1, 1'b1);
    send(1'b1, 32'h0000_010F, 16'h0001, 1'b0, dwec_pkg::RESP_OKAY, 1'b0, 1'b0);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h0);
    apb(1'b1, dwec_pkg::OFS_CTRL, 32'h0);
    $display("test merge done");
    apb(1'b1, dwec_pkg::OFS_RNG_LO, 32'h1000_0000);
    apb(1'b1, dwec_pkg::OFS_RNG_HI, 32'h1000_00FF);
    send(1'b1, 32'h0FFF_FFFF, 16'h0001, 1'b1, dwec_pkg::RESP_OKAY, 1'b1, 1'b0);
    send(1'b1, 32'h1000_0100, 16'h0001, 1'b1, dwec_pkg::RESP_OKAY, 1'b1, 1'b0);
    send(1'b1, 32'h1000_00FF, 16'h0001, 1'b1, dwec_pkg::RESP_ERR, 1'b1, 1'b0);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h1);
    send(1'b0, 32'h1000_0000, 16'h0008, 1'b1, dwec_pkg::RESP_ERR, 1'b0, 1'b0);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h3);
    rdc("count", dwec_pkg::OFS_COUNT, 32'h1);
    chk("abortCnt", 32'h1, {28'h0, abortCnt});
    chk("queueCnt", 32'h4, {28'h0, queueCnt});
    apb(1'b1, dwec_pkg::OFS_CLR, 32'h3);
    rdc("raw", dwec_pkg::OFS_RAW, 32'h0);
    $display("test range done");
    tally_and_finish();
  end
endmodule
